// [timer16_pkg.sv]
// shared constants and types for the sixteen bit timer counter core
package timer16_pkg;
    // i/o location map of the core
    localparam logic [5:0] ADDR_CTRL_A = 6'h00;
    localparam logic [5:0] ADDR_CTRL_B = 6'h01;
    localparam logic [5:0] ADDR_CNT_LO = 6'h02;
    localparam logic [5:0] ADDR_CNT_HI = 6'h03;
    localparam logic [5:0] ADDR_OCA_LO = 6'h04;
    localparam logic [5:0] ADDR_OCA_HI = 6'h05;
    localparam logic [5:0] ADDR_OCB_LO = 6'h06;
    localparam logic [5:0] ADDR_OCB_HI = 6'h07;
    localparam logic [5:0] ADDR_CAP_LO = 6'h08;
    localparam logic [5:0] ADDR_CAP_HI = 6'h09;
    localparam logic [5:0] ADDR_FLAGS = 6'h39;
    localparam logic [5:0] ADDR_MASK = 6'h3a;
    // flag and mask bit positions
    localparam int BIT_OVF = 7;
    localparam int BIT_FLAG_B = 6;
    localparam int BIT_FLAG_A = 5;
    localparam int BIT_MASK_A = 6;
    localparam int BIT_MASK_B = 5;
    localparam int BIT_CAP = 3;
    // control register a and b fields, write masks and reset value
    localparam int BIT_NOISE = 7;
    localparam int BIT_EDGE = 6;
    localparam int WGM_HI_MSB = 4;
    localparam int WGM_HI_LSB = 3;
    localparam int CS_MSB = 2;
    localparam int WGM_LO_MSB = 1;
    localparam logic [7:0] CTRL_B_RW_MASK = 8'hdf;
    localparam logic [7:0] MASK_RW_MASK = 8'he8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // clock select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    // prescaler tap masks
    localparam logic [9:0] PS_M1 = 10'h000;
    localparam logic [9:0] PS_M8 = 10'h007;
    localparam logic [9:0] PS_M64 = 10'h03f;
    localparam logic [9:0] PS_M256 = 10'h0ff;
    localparam logic [9:0] PS_M1024 = 10'h3ff;
    // counter extremes and fixed tops
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] TOP_FIX8 = 16'h00ff;
    localparam logic [15:0] TOP_FIX9 = 16'h01ff;
    localparam logic [15:0] TOP_FIX10 = 16'h03ff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam int FILTER_DEPTH = 4;
    // counting sequence kinds and top sources
    typedef enum logic [1:0] {SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_PHASE}
        seq_kind_t;
    typedef enum logic [2:0] {TOP_MAX, TOP_F8, TOP_F9, TOP_F10,
        TOP_OCA, TOP_CAP} top_src_t;
endpackage

// [capture_edge_unit.sv]
// capture trigger path: source select, optional noise filter, edge detect
`timescale 1ns/1ps
module capture_edge_unit
    import timer16_pkg::*;
#(
    parameter int DEPTH = FILTER_DEPTH
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    input wire logic use_comparator,
    input wire logic noise_enable,
    input wire logic rising_edge_sel,
    input wire logic path_enable,
    output logic event_q
);
    logic [DEPTH-1:0] samp_q;
    logic filt_q;
    logic prev_q;
    logic src;
    logic level;

    // switching source may itself look like an edge, software clears it
    assign src = use_comparator ? comparator_output : capture_input_pin;
    assign level = noise_enable ? filt_q : samp_q[0];

    // sample pipeline, filtered level moves only when all samples agree
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            samp_q <= '0;
            filt_q <= 1'b0;
        end
        else
        begin
            samp_q <= {samp_q[DEPTH-2:0], src};
            if (&samp_q)
                filt_q <= 1'b1;
            else if (~|samp_q)
                filt_q <= 1'b0;
        end
    end

    // edge detector, held quiet while the capture value is the top
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_q <= 1'b0;
            event_q <= 1'b0;
        end
        else
        begin
            prev_q <= level;
            event_q <= path_enable &&
                (rising_edge_sel ? (level && !prev_q) : (!level && prev_q));
        end
    end
endmodule

// [timer16_core.sv]
// sixteen bit timer counter core with byte wide processor access
`timescale 1ns/1ps
module timer16_core
    import timer16_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    output logic [7:0] io_rdata_q,
    input wire logic external_count_pin,
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    input wire logic capture_from_comparator,
    input wire logic ack_overflow,
    input wire logic ack_compare_a,
    input wire logic ack_compare_b,
    input wire logic ack_capture,
    output logic irq_overflow,
    output logic irq_compare_a,
    output logic irq_compare_b,
    output logic irq_capture,
    output logic wave_match_a_q,
    output logic wave_match_b_q,
    output logic wave_top_q,
    output logic wave_bottom_q
);
    logic [7:0] ctrl_a_q, ctrl_b_q, mask_q, temp_q;
    logic [WIDTH-1:0] cnt_q, cnt_d, oca_q, ocb_q, oca_act_q, ocb_act_q;
    logic [WIDTH-1:0] cap_q, top, eff_a, eff_b;
    logic ovf_q, fla_q, flb_q, fcap_q, dir_q, dir_d, blk_q;
    logic [9:0] presc_q;
    logic ext_prev_q, tick, ext_rise, ext_fall, cap_evt;
    logic [3:0] wgm;
    logic [2:0] cs;
    seq_kind_t kind;
    top_src_t tsel;
    logic pwm, at_top, upd, tov_set, cap_top;
    logic wr_cnt, wr_flags, rd_cnt, rd_cap, m_a, m_b;

    // mode decode tables, used for kind and top source
    function automatic seq_kind_t kind_of(input logic [3:0] m);
        case (m)
            4'h0, 4'hd: kind_of = SEQ_NORMAL;
            4'h4, 4'hc: kind_of = SEQ_CTC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: kind_of = SEQ_FAST;
            default: kind_of = SEQ_PHASE;
        endcase
    endfunction

    function automatic top_src_t top_of(input logic [3:0] m);
        case (m)
            4'h1, 4'h5: top_of = TOP_F8;
            4'h2, 4'h6: top_of = TOP_F9;
            4'h3, 4'h7: top_of = TOP_F10;
            4'h4, 4'h9, 4'hb, 4'hf: top_of = TOP_OCA;
            4'h8, 4'ha, 4'hc, 4'he: top_of = TOP_CAP;
            default: top_of = TOP_MAX;
        endcase
    endfunction

    function automatic logic hit(input logic [5:0] a, input logic [5:0] b,
        input logic strobe);
        hit = strobe && (a == b);
    endfunction

    // mode field spans both control registers
    assign wgm = {ctrl_b_q[WGM_HI_MSB:WGM_HI_LSB], ctrl_a_q[WGM_LO_MSB:0]};
    assign cs = ctrl_b_q[CS_MSB:0];
    assign kind = kind_of(wgm);
    assign tsel = top_of(wgm);
    assign pwm = (kind == SEQ_FAST) || (kind == SEQ_PHASE);
    assign cap_top = (tsel == TOP_CAP);
    assign wr_cnt = hit(io_addr, ADDR_CNT_LO, io_we);
    assign wr_flags = hit(io_addr, ADDR_FLAGS, io_we);
    assign rd_cnt = hit(io_addr, ADDR_CNT_LO, io_re);
    assign rd_cap = hit(io_addr, ADDR_CAP_LO, io_re);

    // free running prescaler, never reset by the counter
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            presc_q <= '0;
        else
            presc_q <= presc_q + 10'h001;
    end

    // count pin is synchronous here, one flop suffices for edges
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            ext_prev_q <= 1'b0;
        else
            ext_prev_q <= external_count_pin;
    end

    assign ext_rise = external_count_pin && !ext_prev_q;
    assign ext_fall = !external_count_pin && ext_prev_q;

    // tick source and edge selection
    always_comb
    begin
        case (cs)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (presc_q & PS_M8) == PS_M8;
            CS_DIV64: tick = (presc_q & PS_M64) == PS_M64;
            CS_DIV256: tick = (presc_q & PS_M256) == PS_M256;
            CS_DIV1024: tick = (presc_q & PS_M1024) == PS_M1024;
            CS_EXT_FALL: tick = ext_fall;
            default: tick = ext_rise;
        endcase
    end

    // top source per mode; compare a uses its buffered copy in pwm
    always_comb
    begin
        case (tsel)
            TOP_F8: top = TOP_FIX8;
            TOP_F9: top = TOP_FIX9;
            TOP_F10: top = TOP_FIX10;
            TOP_OCA: top = eff_a;
            TOP_CAP: top = cap_q;
            default: top = CNT_MAX;
        endcase
    end

    // non pwm modes compare against the written value directly
    assign eff_a = pwm ? oca_act_q : oca_q;
    assign eff_b = pwm ? ocb_act_q : ocb_q;
    assign m_a = (cnt_q == eff_a);
    assign m_b = (cnt_q == eff_b);

    // next count, direction and sequence events
    always_comb
    begin
        cnt_d = cnt_q + CNT_ONE;
        dir_d = dir_q;
        at_top = 1'b0;
        upd = 1'b0;
        tov_set = 1'b0;
        case (kind)
            SEQ_CTC:
            begin
                at_top = (cnt_q == top);
                if (at_top)
                    cnt_d = CNT_BOTTOM;
                tov_set = (cnt_q == CNT_MAX);
            end
            SEQ_FAST:
            begin
                at_top = (cnt_q >= top);
                if (at_top)
                    cnt_d = CNT_BOTTOM;
                tov_set = at_top;
                upd = at_top;
            end
            SEQ_PHASE:
            begin
                if (dir_q)
                begin
                    at_top = (cnt_q >= top);
                    if (at_top)
                    begin
                        dir_d = 1'b0;
                        cnt_d = cnt_q - CNT_ONE;
                    end
                end
                else if (cnt_q == CNT_BOTTOM)
                begin
                    dir_d = 1'b1;
                    tov_set = 1'b1;
                end
                else
                    cnt_d = cnt_q - CNT_ONE;
                // modes eight and nine refresh at bottom, others at top
                upd = (wgm[3:1] == 3'h4) ? tov_set : at_top;
            end
            default:
                tov_set = (cnt_q == CNT_MAX);
        endcase
    end

    // counter: processor write always wins over a hardware step
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_q <= CNT_BOTTOM;
            dir_q <= 1'b1;
        end
        else if (wr_cnt)
            cnt_q <= {temp_q, io_wdata};
        else if (tick)
        begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // a counter write hides the compare match on the next tick
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            blk_q <= 1'b0;
        else if (wr_cnt)
            blk_q <= 1'b1;
        else if (tick)
            blk_q <= 1'b0;
    end

    // shared high byte latch for all sixteen bit writes; only count and capture reads use it
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            temp_q <= 8'h00;
        else if (rd_cnt)
            temp_q <= cnt_q[15:8];
        else if (rd_cap)
            temp_q <= cap_q[15:8];
        else if (io_we && (io_addr == ADDR_CNT_HI || io_addr == ADDR_OCA_HI
            || io_addr == ADDR_OCB_HI || io_addr == ADDR_CAP_HI))
            temp_q <= io_wdata;
    end

    // control and mask bytes, written directly
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_a_q <= CTRL_RESET;
            ctrl_b_q <= CTRL_RESET;
            mask_q <= CTRL_RESET;
        end
        else if (io_we)
        begin
            if (io_addr == ADDR_CTRL_A)
                ctrl_a_q <= io_wdata;
            if (io_addr == ADDR_CTRL_B)
                ctrl_b_q <= io_wdata & CTRL_B_RW_MASK;
            if (io_addr == ADDR_MASK)
                mask_q <= io_wdata & MASK_RW_MASK;
        end
    end

    // compare registers and their double buffers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            oca_q <= '0;
            ocb_q <= '0;
            oca_act_q <= '0;
            ocb_act_q <= '0;
        end
        else
        begin
            if (hit(io_addr, ADDR_OCA_LO, io_we))
                oca_q <= {temp_q, io_wdata};
            if (hit(io_addr, ADDR_OCB_LO, io_we))
                ocb_q <= {temp_q, io_wdata};
            // buffers follow at the mode's refresh point only in pwm
            if (!pwm || (tick && upd))
            begin
                oca_act_q <= oca_q;
                ocb_act_q <= ocb_q;
            end
        end
    end

    // capture register: hardware events, processor only in top modes
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            cap_q <= '0;
        else if (cap_evt)
            cap_q <= cnt_q;
        else if (cap_top && hit(io_addr, ADDR_CAP_LO, io_we))
            cap_q <= {temp_q, io_wdata};
    end

    capture_edge_unit #(.DEPTH(FILTER_DEPTH)) u_cap
    (
        .mclk(mclk),
        .resetn(resetn),
        .capture_input_pin(capture_input_pin),
        .comparator_output(comparator_output),
        .use_comparator(capture_from_comparator),
        .noise_enable(ctrl_b_q[BIT_NOISE]),
        .rising_edge_sel(ctrl_b_q[BIT_EDGE]),
        .path_enable(!cap_top),
        .event_q(cap_evt)
    );

    // sticky flags: a set in the clearing cycle survives
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ovf_q <= 1'b0;
            fla_q <= 1'b0;
            flb_q <= 1'b0;
            fcap_q <= 1'b0;
        end
        else
        begin
            ovf_q <= (tick && tov_set && !wr_cnt) || (ovf_q && !ack_overflow
                && !(wr_flags && io_wdata[BIT_OVF]));
            fla_q <= (tick && m_a && !blk_q && !wr_cnt) || (fla_q
                && !ack_compare_a && !(wr_flags && io_wdata[BIT_FLAG_A]));
            flb_q <= (tick && m_b && !blk_q && !wr_cnt) || (flb_q
                && !ack_compare_b && !(wr_flags && io_wdata[BIT_FLAG_B]));
            fcap_q <= cap_evt || (fcap_q && !ack_capture
                && !(wr_flags && io_wdata[BIT_CAP]));
        end
    end

    // each source masked on its own
    assign irq_overflow = ovf_q && mask_q[BIT_OVF];
    assign irq_compare_a = fla_q && mask_q[BIT_MASK_A];
    assign irq_compare_b = flb_q && mask_q[BIT_MASK_B];
    assign irq_capture = fcap_q && mask_q[BIT_CAP];

    // match pulses for the waveform generator, a silent when it is top in pwm modes
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wave_match_a_q <= 1'b0;
            wave_match_b_q <= 1'b0;
            wave_top_q <= 1'b0;
            wave_bottom_q <= 1'b0;
        end
        else
        begin
            wave_match_a_q <= tick && m_a && !blk_q
                && !(pwm && tsel == TOP_OCA);
            wave_match_b_q <= tick && m_b && !blk_q;
            wave_top_q <= tick && at_top;
            wave_bottom_q <= tick && (cnt_q == CNT_BOTTOM);
        end
    end

    // registered read port, one cycle after the strobe
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            io_rdata_q <= 8'h00;
        else if (io_re)
        begin
            case (io_addr)
                ADDR_CTRL_A: io_rdata_q <= ctrl_a_q;
                ADDR_CTRL_B: io_rdata_q <= ctrl_b_q;
                ADDR_CNT_LO: io_rdata_q <= cnt_q[7:0];
                ADDR_CNT_HI, ADDR_CAP_HI: io_rdata_q <= temp_q;
                ADDR_OCA_LO: io_rdata_q <= oca_q[7:0];
                ADDR_OCA_HI: io_rdata_q <= oca_q[15:8];
                ADDR_OCB_LO: io_rdata_q <= ocb_q[7:0];
                ADDR_OCB_HI: io_rdata_q <= ocb_q[15:8];
                ADDR_CAP_LO: io_rdata_q <= cap_q[7:0];
                ADDR_FLAGS: io_rdata_q <= {ovf_q, flb_q, fla_q, 1'b0, fcap_q,
                    3'h0};
                ADDR_MASK: io_rdata_q <= mask_q;
                default: io_rdata_q <= 8'h00;
            endcase
        end
    end

    // checks on the design's own behaviour
    sequence s_hi_lo;
        hit(io_addr, ADDR_CNT_HI, io_we) ##1 hit(io_addr, ADDR_CNT_LO, io_we);
    endsequence
    property p_stop;
        @(posedge mclk) disable iff (!resetn)
            (cs == CS_STOP) && !wr_cnt |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");
    property p_pair;
        @(posedge mclk) disable iff (!resetn)
            s_hi_lo |=> cnt_q[15:8] == $past(io_wdata, 2);
    endproperty
    a_pair: assert property (p_pair) else $error("high byte lost");
    property p_cpu_wins;
        @(posedge mclk) disable iff (!resetn)
            wr_cnt && tick |=> cnt_q == {$past(temp_q), $past(io_wdata)};
    endproperty
    a_cpu_wins: assert property (p_cpu_wins) else $error("write lost");
    property p_latch;
        @(posedge mclk) disable iff (!resetn)
            rd_cnt |=> temp_q == $past(cnt_q[15:8]);
    endproperty
    a_latch: assert property (p_latch) else $error("latch not loaded");
    property p_cap_latch;
        @(posedge mclk) disable iff (!resetn)
            rd_cap && !rd_cnt |=> temp_q == $past(cap_q[15:8]);
    endproperty
    a_cap_latch: assert property (p_cap_latch) else $error("cap latch");
    property p_cmp;
        @(posedge mclk) disable iff (!resetn)
            tick && m_a && !blk_q && !wr_cnt |=> fla_q;
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare flag missed");
    property p_capture;
        @(posedge mclk) disable iff (!resetn)
            cap_evt |=> fcap_q && cap_q == $past(cnt_q);
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");
    property p_cap_ack;
        @(posedge mclk) disable iff (!resetn)
            fcap_q && ack_capture && !cap_evt |=> !fcap_q;
    endproperty
    a_cap_ack: assert property (p_cap_ack) else $error("flag stuck");
    property p_up;
        @(posedge mclk) disable iff (!resetn)
            tick && kind == SEQ_NORMAL && !wr_cnt
                |=> cnt_q == $past(cnt_q) + CNT_ONE;
    endproperty
    a_up: assert property (p_up) else $error("count step wrong");
    property p_ovf;
        @(posedge mclk) disable iff (!resetn)
            tick && kind == SEQ_NORMAL && cnt_q == CNT_MAX && !wr_cnt
                |=> ovf_q && cnt_q == CNT_BOTTOM;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow missed");
endmodule

// [cpu_model.sv]
// processor side model: byte wide i/o reads and writes
`timescale 1ns/1ps
module cpu_model
(
    input wire logic mclk,
    input wire logic [7:0] io_rdata_q,
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_we,
    output logic io_re
);
    // idle bus, strobes low from time zero
    initial
    begin
        io_addr = 6'h00;
        io_wdata = 8'h00;
        io_we = 1'b0;
        io_re = 1'b0;
    end
    // one write, request held until the taking edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(posedge mclk);
        #1;
        io_we = 1'b0;
        io_wdata = ~d; // released bus never shows the old byte
    endtask
    // one read, data settled the cycle after the taking edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        io_addr = a;
        io_re = 1'b1;
        @(posedge mclk);
        #1;
        d = io_rdata_q;
        io_re = 1'b0;
    endtask
    // low byte first so the shared latch holds the matching high byte
    task automatic rd16(input logic [5:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 6'h01, d[15:8]);
    endtask
    // high byte first, low byte commits both
    task automatic wr16(input logic [5:0] a, input logic [15:0] d);
        wr(a + 6'h01, d[15:8]);
        wr(a, d[7:0]);
    endtask
endmodule

// [timer16_core_tb.sv]
// self-checking bench for the sixteen bit timer counter core
`timescale 1ns/1ps
module timer16_core_tb;
    import timer16_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata_q, b;
    logic io_we, io_re, ext_pin, cap_pin, cmp_pin, cap_sel;
    logic [3:0] ack, irq, wave;
    logic [15:0] v, w;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int n[4], n0[4];
    timer16_core u_timer16_core (.mclk(mclk), .resetn(resetn),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
        .io_re(io_re), .io_rdata_q(io_rdata_q),
        .external_count_pin(ext_pin), .capture_input_pin(cap_pin),
        .comparator_output(cmp_pin), .capture_from_comparator(cap_sel),
        .ack_overflow(ack[0]), .ack_compare_a(ack[1]),
        .ack_compare_b(ack[2]), .ack_capture(ack[3]),
        .irq_overflow(irq[0]), .irq_compare_a(irq[1]),
        .irq_compare_b(irq[2]), .irq_capture(irq[3]),
        .wave_match_a_q(wave[0]), .wave_match_b_q(wave[1]),
        .wave_top_q(wave[2]), .wave_bottom_q(wave[3]));
    cpu_model u_cpu_model (.mclk(mclk), .io_rdata_q(io_rdata_q),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
        .io_re(io_re));
    always #2 mclk = ~mclk;
    // pulse counters for the waveform generator outputs
    always @(posedge mclk)
        for (int k = 0; k < 4; k++)
            if (wave[k])
                n[k] <= n[k] + 1;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            test_done();
        end
    end
    task automatic chk16(input string n, input logic [15:0] e, s);
        checked = checked + 1;
        if (s !== e)
        begin
            fail_count = fail_count + 1;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk1(input string n, input logic e, s);
        chk16(n, {15'h0000, e}, {15'h0000, s});
    endtask
    task automatic rchk(input string n, input logic [5:0] a, logic [7:0] e);
        u_cpu_model.rd(a, b);
        chk16(n, {8'h00, e}, {8'h00, b});
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic test_done();
        if (fail_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        {ext_pin, cap_pin, cmp_pin, cap_sel, ack} = 8'h00;
        v = 16'($urandom(32'h19cb));
        ticks(3);
        resetn = 1'b1;
        // reset values, plain byte registers, unmapped place
        rchk("ctrl_b", ADDR_CTRL_B, 8'h00);
        rchk("flags", ADDR_FLAGS, 8'h00);
        rchk("mask", ADDR_MASK, 8'h00);
        b = 8'($urandom());
        u_cpu_model.wr(ADDR_CTRL_A, b);
        rchk("ctrl_a", ADDR_CTRL_A, b);
        u_cpu_model.wr(ADDR_CTRL_A, 8'h00);
        w = 16'($urandom()) & 16'h00f8;
        u_cpu_model.wr(ADDR_CTRL_B, w[7:0]);
        rchk("ctrl_b", ADDR_CTRL_B, w[7:0] & CTRL_B_RW_MASK);
        u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
        rchk("unmapped", 6'h20, 8'h00);
        // stopped counter keeps a written value
        u_cpu_model.wr16(ADDR_CNT_LO, v);
        ticks(20);
        u_cpu_model.rd16(ADDR_CNT_LO, w);
        chk16("cnt", v, w);
        // count pin, falling then rising edge
        for (int cs = 6; cs < 8; cs++)
        begin
            u_cpu_model.wr(ADDR_CTRL_B, cs[7:0]);
            repeat (5)
            begin
                ext_pin = 1'b1;
                ticks(3);
                ext_pin = 1'b0;
                ticks(3);
            end
            u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
            u_cpu_model.rd16(ADDR_CNT_LO, w);
            chk16("cnt_pin", v + 16'h0005, w);
            v = w;
        end
        // latch keeps the high byte while the counter runs on
        u_cpu_model.wr16(ADDR_CNT_LO, 16'h00f0);
        u_cpu_model.wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        u_cpu_model.rd(ADDR_CNT_LO, b);
        ticks(40);
        rchk("latch", ADDR_CNT_HI, 8'h00);
        u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
        u_cpu_model.rd16(ADDR_CNT_LO, w);
        chk16("cnt_up", 16'h011e, w);
        // write while running wins, then eighty cycles of the /8 tap
        u_cpu_model.wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        u_cpu_model.wr16(ADDR_CNT_LO, v);
        u_cpu_model.wr(ADDR_CTRL_B, {5'h00, CS_DIV8});
        ticks(78);
        u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
        u_cpu_model.rd16(ADDR_CNT_LO, w);
        chk16("cnt_wr_div8", v + 16'h000c, w);
        // wrap through zero: overflow plus both compares at zero
        u_cpu_model.wr(ADDR_FLAGS, 8'hff);
        u_cpu_model.wr16(ADDR_CNT_LO, 16'hfff0);
        u_cpu_model.wr(ADDR_MASK, 8'h80);
        u_cpu_model.wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        ticks(40);
        u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
        chk1("irq_ovf", 1'b1, irq[0]);
        rchk("flags", ADDR_FLAGS, 8'he0);
        u_cpu_model.wr(ADDR_FLAGS, 8'h80);
        rchk("flags", ADDR_FLAGS, 8'h60);
        for (int i = 1; i < 3; i++)
        begin
            ack[i] = 1'b1;
            ticks(1);
            ack[i] = 1'b0;
        end
        rchk("flags", ADDR_FLAGS, 8'h00);
        // random compare value reached, second one not
        v = 16'($urandom());
        u_cpu_model.wr16(ADDR_OCA_LO, v);
        u_cpu_model.wr16(ADDR_OCB_LO, v + 16'h0100);
        u_cpu_model.wr16(ADDR_CNT_LO, v - 16'h0008);
        u_cpu_model.wr(ADDR_MASK, 8'h60);
        u_cpu_model.wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        ticks(30);
        u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
        chk1("irq_a", 1'b1, irq[1]);
        chk1("irq_b", 1'b0, irq[2]);
        // capture of a stopped counter, pin then comparator
        u_cpu_model.wr(ADDR_CTRL_B, 8'h40);
        u_cpu_model.wr(ADDR_FLAGS, 8'hff);
        u_cpu_model.wr(ADDR_MASK, 8'h08);
        cap_pin = 1'b1;
        ticks(8);
        chk1("irq_cap", 1'b1, irq[3]);
        u_cpu_model.rd16(ADDR_CAP_LO, w);
        chk16("cap", v - 16'h0008 + 16'h0020, w);
        ack[3] = 1'b1;
        ticks(1);
        ack[3] = 1'b0;
        chk1("irq_cap", 1'b0, irq[3]);
        cap_sel = 1'b1;
        ticks(8);
        u_cpu_model.wr(ADDR_FLAGS, 8'hff);
        v = 16'($urandom());
        u_cpu_model.wr16(ADDR_CNT_LO, v);
        // noise filter on for the comparator path
        u_cpu_model.wr(ADDR_CTRL_B, 8'hc0);
        cmp_pin = 1'b1;
        ticks(8);
        u_cpu_model.rd16(ADDR_CAP_LO, w);
        chk16("cap_cmp", v, w);
        // fast pwm, compare a as top: a pulses silenced, b, top, bottom
        u_cpu_model.wr16(ADDR_OCA_LO, 16'h0009);
        u_cpu_model.wr16(ADDR_OCB_LO, 16'h0004);
        u_cpu_model.wr16(ADDR_CNT_LO, CNT_BOTTOM);
        u_cpu_model.wr(ADDR_CTRL_A, 8'h03);
        n0 = n;
        u_cpu_model.wr(ADDR_CTRL_B, 8'h19);
        ticks(21);
        u_cpu_model.wr(ADDR_CTRL_B, 8'h00);
        u_cpu_model.rd16(ADDR_CNT_LO, w);
        chk16("cnt_pwm", 16'h0003, w);
        chk16("wave_a", 16'h0000, 16'(n[0] - n0[0]));
        chk16("wave_b", 16'h0002, 16'(n[1] - n0[1]));
        chk16("wave_top", 16'h0002, 16'(n[2] - n0[2]));
        chk16("wave_bottom", 16'h0003, 16'(n[3] - n0[3]));
        test_done();
    end
endmodule
